// ==== src/rsic_top.sv ====
// Purpose: Combines reset sources, records the cause and steers core init values.
// Assumes: All inputs except the async reset i_rst_n synchronous to i_mclk; event inputs are one-cycle pulses.
// Notes:   Core holds defined-state registers at reset values while o_core_rst_n is low.
`timescale 1ns/1ps
module rsic_top #(
  parameter int FILT_CYC = rsic_pkg::CLR_FILT_CYC,
  parameter int HOLD_CYC = rsic_pkg::RST_HOLD_CYC
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clear_pin_n,
  input  wire logic        i_brownout,
  input  wire logic        i_watchdog_expire,
  input  wire logic        i_reset_instr,
  input  wire logic        i_stack_full,
  input  wire logic        i_stack_underflow,
  input  wire logic        i_sleeping,
  input  wire logic        i_wake_irq,
  input  wire logic        i_irq_high,
  input  wire logic        i_high_priority_global_enable,
  input  wire logic        i_low_priority_global_enable,
  input  wire logic [20:0] i_pc,
  input  wire logic [4:0]  i_stack_pointer,
  input  wire logic        i_irq_ctrl_keep,
  input  wire logic [7:0]  i_port_a_pins,
  input  wire logic [7:0]  i_port_a_latch,
  input  wire logic [7:0]  i_port_a_direction,
  input  wire logic [2:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  output logic             o_core_rst_n,
  output logic             o_gpr_cold,
  output logic             o_long_write_clr,
  output logic      [7:0]  o_irq_ctrl_value,
  output logic             o_pc_load,
  output logic      [20:0] o_pc_value,
  output logic             o_tos_load,
  output logic      [20:0] o_tos_value,
  output logic      [4:0]  o_stack_pointer_value,
  output logic      [1:0]  o_wake_flag_set,
  output logic      [7:0]  o_port_a_pins,
  output logic      [7:0]  o_port_a_latch,
  output logic      [7:0]  o_port_a_direction,
  output logic             o_irq
);

  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam logic [HW-1:0] HOLD_LOAD = HW'(HOLD_CYC);

  if (HOLD_CYC < 1 || FILT_CYC < 1) begin : g_bad
    $error("HOLD_CYC and FILT_CYC must be at least 1");
  end

  // ************************************
  // Master clear filter
  // ************************************
  rsic_filt_if clr_if ();

  assign clr_if.pin_n = i_clear_pin_n;

  rsic_pin_filter #(
    .FILT_CYC (FILT_CYC)
  ) u_filter (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .f       (clr_if)
  );

  // ************************************
  // Source detection
  // ************************************
  rsic_pkg::rsic_state_t state;
  rsic_pkg::rsic_state_t next_state;
  logic [HW-1:0] hold_cnt;
  logic          brownout_q;
  logic [7:0]    ev;
  logic [7:0]    ev_pick;
  logic          src_now;
  logic          running;
  logic          wake_ev;
  logic          wake_gie;
  logic [4:0]    cause;
  logic [7:0]    last_cause;
  logic [7:0]    status;
  logic [7:0]    mask;
  logic [2:0]    osc_mode;
  logic          port_a6_en;

  assign running = (state == rsic_pkg::RSIC_ST_RUN);

  // Core-issued events count only while the core runs
  always_comb begin
    ev = '0;
    ev[rsic_pkg::EV_PIN_RUN]  = clr_if.assert_pulse && !i_sleeping;
    ev[rsic_pkg::EV_PIN_SLP]  = clr_if.assert_pulse && i_sleeping;
    ev[rsic_pkg::EV_WATCHDOG] = i_watchdog_expire && !i_sleeping && running;
    ev[rsic_pkg::EV_BROWNOUT] = i_brownout && !brownout_q;
    ev[rsic_pkg::EV_INSTR]    = i_reset_instr && running;
    ev[rsic_pkg::EV_STKF]     = i_stack_full && running;
    ev[rsic_pkg::EV_STKU]     = i_stack_underflow && running;
  end

  // Lowest index wins when causes coincide
  assign ev_pick  = ev & (~ev + 8'h01);
  // Pin only read through the filter; nothing here drives it
  assign src_now  = clr_if.asserted || i_brownout || (|ev);
  assign wake_ev  = running && i_sleeping && (i_wake_irq || i_watchdog_expire) && !src_now;
  assign wake_gie = wake_ev && i_wake_irq
                    && (i_high_priority_global_enable || i_low_priority_global_enable);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      brownout_q <= 1'b0;
    end else begin
      brownout_q <= i_brownout;
    end
  end

  // ************************************
  // Reset sequencer
  // ************************************
  always_comb begin
    next_state = state;
    unique case (state)
      rsic_pkg::RSIC_ST_RUN: begin
        if (src_now) begin
          next_state = rsic_pkg::RSIC_ST_HOLD;
        end
      end
      rsic_pkg::RSIC_ST_HOLD: begin
        if (!src_now && hold_cnt == '0) begin
          next_state = rsic_pkg::RSIC_ST_RUN;
        end
      end
    endcase
  end

  // Counter reloads while any source is active, so release trails the last one
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state        <= rsic_pkg::RSIC_ST_HOLD;
      hold_cnt     <= HOLD_LOAD;
      o_core_rst_n <= 1'b0;
    end else begin
      state        <= next_state;
      o_core_rst_n <= (next_state == rsic_pkg::RSIC_ST_RUN);
      if (src_now) begin
        hold_cnt <= HOLD_LOAD;
      end else if (hold_cnt != '0) begin
        hold_cnt <= hold_cnt - HW'(1);
      end
    end
  end

  // Stays high only until the first release after power-on
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_gpr_cold <= 1'b1;
    end else if (running) begin
      o_gpr_cold <= 1'b0;
    end
  end

  // Cold reset starts with the clear pending; warm entries decide afresh
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_long_write_clr <= 1'b1;
    end else if (running && src_now) begin
      o_long_write_clr <= clr_if.assert_pulse;
    end else if (!running) begin
      o_long_write_clr <= o_long_write_clr || clr_if.assert_pulse;
    end else begin
      o_long_write_clr <= 1'b0;
    end
  end

  // Value the core loads into interrupt control during reset
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_ctrl_value <= '0;
    end else if (running && src_now) begin
      o_irq_ctrl_value <= {rsic_pkg::IRQ_CTRL_RST_HI, i_irq_ctrl_keep};
    end
  end

  // ************************************
  // Wake from sleep
  // ************************************
  // Wake never enters the hold state, so no reset values are applied
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pc_load             <= 1'b0;
      o_pc_value            <= '0;
      o_tos_load            <= 1'b0;
      o_tos_value           <= '0;
      o_stack_pointer_value <= '0;
      o_wake_flag_set       <= '0;
    end else begin
      o_pc_load       <= wake_ev;
      o_tos_load      <= wake_gie;
      o_wake_flag_set <= {wake_ev && !i_wake_irq, wake_ev && i_wake_irq};
      if (wake_gie) begin
        o_pc_value            <= i_irq_high ? rsic_pkg::VEC_HIGH : rsic_pkg::VEC_LOW;
        o_tos_value           <= i_pc;
        o_stack_pointer_value <= i_stack_pointer + rsic_pkg::SP_STEP;
      end else if (wake_ev) begin
        o_pc_value <= i_pc + rsic_pkg::PC_STEP;
      end
    end
  end

  // ************************************
  // Cause flags and event status
  // ************************************
  // Hardware updates beat a same-cycle software write
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cause <= rsic_pkg::CAUSE_COLD;
    end else if (|ev_pick) begin
      if (ev_pick[rsic_pkg::EV_PIN_SLP]) begin
        cause[rsic_pkg::FLG_EXPIRED]  <= 1'b1;
        cause[rsic_pkg::FLG_PWR_DOWN] <= 1'b0;
      end
      if (ev_pick[rsic_pkg::EV_WATCHDOG]) begin
        cause[rsic_pkg::FLG_EXPIRED]  <= 1'b0;
        cause[rsic_pkg::FLG_PWR_DOWN] <= 1'b1;
      end
      if (ev_pick[rsic_pkg::EV_BROWNOUT]) begin
        cause[rsic_pkg::FLG_INSTR]    <= 1'b1;
        cause[rsic_pkg::FLG_EXPIRED]  <= 1'b1;
        cause[rsic_pkg::FLG_PWR_DOWN] <= 1'b1;
        cause[rsic_pkg::FLG_BROWNOUT] <= 1'b0;
      end
      if (ev_pick[rsic_pkg::EV_INSTR]) begin
        cause[rsic_pkg::FLG_INSTR] <= 1'b0;
      end
    end else if (wake_ev) begin
      cause[rsic_pkg::FLG_EXPIRED]  <= i_wake_irq;
      cause[rsic_pkg::FLG_PWR_DOWN] <= 1'b0;
    end else if (i_wr && i_addr == rsic_pkg::ADDR_CAUSE) begin
      cause <= (cause & ~rsic_pkg::CAUSE_SW_WR) | (i_wdata[4:0] & rsic_pkg::CAUSE_SW_WR);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_cause <= rsic_pkg::LAST_COLD;
    end else if (|ev_pick) begin
      last_cause <= ev_pick;
    end
  end

  // Sticky: a new event survives a same-cycle write-one clear
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status <= rsic_pkg::STATUS_COLD;
    end else if (i_wr && i_addr == rsic_pkg::ADDR_STATUS) begin
      status <= (status & ~i_wdata) | ev;
    end else begin
      status <= status | ev;
    end
  end

  assign o_irq = |(status & mask);

  // ************************************
  // Register port
  // ************************************
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask     <= rsic_pkg::MASK_COLD;
      osc_mode <= rsic_pkg::CTRL_COLD;
    end else if (i_wr) begin
      if (i_addr == rsic_pkg::ADDR_MASK) begin
        mask <= i_wdata;
      end
      if (i_addr == rsic_pkg::ADDR_CTRL) begin
        osc_mode <= i_wdata[2:0];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        rsic_pkg::ADDR_CAUSE:  o_rdata <= {3'h0, cause};
        rsic_pkg::ADDR_LAST:   o_rdata <= last_cause;
        rsic_pkg::ADDR_STATUS: o_rdata <= status;
        rsic_pkg::ADDR_MASK:   o_rdata <= mask;
        rsic_pkg::ADDR_CTRL:   o_rdata <= {5'h00, osc_mode};
        default:               o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // ************************************
  // Port A bit 6 gating
  // ************************************
  assign port_a6_en = (osc_mode == rsic_pkg::OSC_EXT_IO) || (osc_mode == rsic_pkg::OSC_RCAP_IO);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_port_a_pins      <= '0;
      o_port_a_latch     <= '0;
      o_port_a_direction <= '0;
    end else begin
      o_port_a_pins      <= rsic_pkg::rsic_gate_bit6(i_port_a_pins, port_a6_en);
      o_port_a_latch     <= rsic_pkg::rsic_gate_bit6(i_port_a_latch, port_a6_en);
      o_port_a_direction <= rsic_pkg::rsic_gate_bit6(i_port_a_direction, port_a6_en);
    end
  end

  // ************************************
  // Checks
  // ************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  src_holds_a: assert property (src_now |=> !o_core_rst_n)
    else $error("core reset released while a source is active");
  release_late_a: assert property ($rose(o_core_rst_n) |-> $past(!src_now, 1))
    else $error("core reset released without a quiet cycle");
  reset_loads_a: assert property ((running && src_now) |=> !o_core_rst_n
    && o_irq_ctrl_value[7:1] == rsic_pkg::IRQ_CTRL_RST_HI)
    else $error("reset did not apply defined values");
  wake_noreset_a: assert property (wake_ev |=> o_core_rst_n && o_pc_load)
    else $error("wake applied a reset");
  wake_vector_a: assert property (wake_gie |=> o_pc_value ==
    ($past(i_irq_high) ? rsic_pkg::VEC_HIGH : rsic_pkg::VEC_LOW))
    else $error("wrong wake vector");
  wake_push_a: assert property (wake_gie |=> o_tos_load && o_tos_value == $past(i_pc)
    && o_stack_pointer_value == $past(i_stack_pointer) + rsic_pkg::SP_STEP)
    else $error("stack not pushed on wake");
  wake_flag_a: assert property (wake_ev |=> o_wake_flag_set != 2'h0)
    else $error("wake left no flag");
  watchdog_flags_a: assert property (ev_pick[rsic_pkg::EV_WATCHDOG] |=>
    !cause[rsic_pkg::FLG_EXPIRED] && cause[rsic_pkg::FLG_PWR_DOWN])
    else $error("watchdog flags wrong");
  instr_flag_a: assert property (ev_pick[rsic_pkg::EV_INSTR] |=>
    !cause[rsic_pkg::FLG_INSTR])
    else $error("instruction flag not cleared");
  cause_onehot_a: assert property ($onehot(last_cause))
    else $error("last cause not one-hot");
  gpr_cold_a: assert property ((!o_gpr_cold || o_core_rst_n) |=> !o_gpr_cold)
    else $error("general registers marked unknown after warm reset");
  lwe_keep_a: assert property ((running && src_now && !clr_if.assert_pulse)
    |=> !o_long_write_clr)
    else $error("long write enable cleared by wrong reset");
  port_gate_a: assert property (!port_a6_en |=> !o_port_a_pins[6]
    && !o_port_a_latch[6] && !o_port_a_direction[6])
    else $error("port A bit 6 visible in wrong mode");

endmodule

// ==== src/rsic_pkg.sv ====
// Purpose: Shared constants and types for the reset source and init control block.
// Assumes: 50 MHz system clock; async active-low power-on reset.
// Notes:   Register indices address the 8-bit register port directly.
package rsic_pkg;

  // ************************************
  // Timing
  // ************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLR_FILT_NS   = 200;
  localparam int CLR_FILT_CYC  = (CLR_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_HOLD_NS   = 20;
  localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************
  // Register map
  // ************************************
  localparam logic [2:0] ADDR_CAUSE  = 3'h0;
  localparam logic [2:0] ADDR_LAST   = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_MASK   = 3'h3;
  localparam logic [2:0] ADDR_CTRL   = 3'h4;

  // Cause flag positions in the reset cause register
  localparam int FLG_BROWNOUT = 0;
  localparam int FLG_POR      = 1;
  localparam int FLG_PWR_DOWN = 2;
  localparam int FLG_EXPIRED  = 3;
  localparam int FLG_INSTR    = 4;
  localparam logic [4:0] CAUSE_COLD  = 5'h1c;
  localparam logic [4:0] CAUSE_SW_WR = 5'h13;

  // Cause indices in last-cause and status registers
  localparam int EV_POR      = 0;
  localparam int EV_PIN_RUN  = 1;
  localparam int EV_PIN_SLP  = 2;
  localparam int EV_WATCHDOG = 3;
  localparam int EV_BROWNOUT = 4;
  localparam int EV_INSTR    = 5;
  localparam int EV_STKF     = 6;
  localparam int EV_STKU     = 7;
  localparam logic [7:0] LAST_COLD   = 8'h01;
  localparam logic [7:0] STATUS_COLD = 8'h01;
  localparam logic [7:0] MASK_COLD   = 8'h00;

  // ************************************
  // Core-facing values
  // ************************************
  localparam logic [20:0] VEC_HIGH = 21'h000008;
  localparam logic [20:0] VEC_LOW  = 21'h000018;
  localparam logic [20:0] PC_STEP  = 21'h000002;
  localparam logic [4:0]  SP_STEP  = 5'h01;
  localparam logic [6:0]  IRQ_CTRL_RST_HI = 7'h00;
  localparam logic [2:0]  OSC_EXT_IO  = 3'h5;
  localparam logic [2:0]  OSC_RCAP_IO = 3'h7;
  localparam logic [2:0]  CTRL_COLD   = 3'h0;
  localparam int PORT_A_GATED_BIT = 6;

  typedef enum logic {RSIC_ST_RUN, RSIC_ST_HOLD} rsic_state_t;

  // Clears the gated port A bit when the oscillator owns the pin
  function automatic logic [7:0] rsic_gate_bit6(input logic [7:0] v, input logic en);
    logic [7:0] r;
    r = v;
    r[PORT_A_GATED_BIT] = v[PORT_A_GATED_BIT] & en;
    return r;
  endfunction

endpackage

// ==== src/rsic_filt_if.sv ====
// Purpose: Carries the master clear pin level to the filter and the verdict back.
// Assumes: Single clock domain.
// Notes:   The pin is only ever read.
`timescale 1ns/1ps
interface rsic_filt_if;
  logic pin_n;
  logic asserted;
  logic assert_pulse;
  modport filt (input pin_n, output asserted, output assert_pulse);
  modport core (output pin_n, input asserted, input assert_pulse);
endinterface

// ==== src/rsic_master_clear_pin_filter.sv ====
// Purpose: Rejects short low pulses on the master clear pin.
// Assumes: Pin already synchronous to i_mclk.
// Notes:   Release is immediate; only assertion is qualified.
`timescale 1ns/1ps
module rsic_pin_filter #(
  parameter int FILT_CYC = rsic_pkg::CLR_FILT_CYC
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  rsic_filt_if.filt f
);
  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] FILT_LAST = CW'(FILT_CYC - 1);

  if (FILT_CYC < 1) begin : g_bad
    $error("FILT_CYC must be at least 1");
  end

  logic [CW-1:0] low_cnt;
  logic          asserted;
  logic          assert_pulse;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_cnt <= '0;
    end else if (f.pin_n) begin
      low_cnt <= '0;
    end else if (low_cnt != FILT_LAST) begin
      low_cnt <= low_cnt + CW'(1);
    end
  end

  // A pulse shorter than FILT_CYC samples never reaches asserted
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      asserted     <= 1'b0;
      assert_pulse <= 1'b0;
    end else begin
      asserted     <= !f.pin_n && (low_cnt == FILT_LAST);
      assert_pulse <= !f.pin_n && (low_cnt == FILT_LAST) && !asserted;
    end
  end

  assign f.asserted     = asserted;
  assign f.assert_pulse = assert_pulse;

  short_pulse_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(asserted) |-> $past(!f.pin_n) && $past(low_cnt) == FILT_LAST)
    else $error("master clear asserted before filter time");

endmodule

// ==== testbench/rsic_far_side.sv ====
// Purpose: Far-side model of the master clear pin and the supply and watchdog monitors.
// Assumes: The bench changes requests just after a rising clock edge.
// Notes:   The pin has a pull-up, so a released pin reads high.
`timescale 1ns/1ps
module rsic_far_side (
  input  wire logic i_pin_hold,
  input  wire logic i_brownout_req,
  input  wire logic i_watchdog_req,
  output logic      o_clear_pin_n,
  output logic      o_brownout,
  output logic      o_watchdog_expire
);
  // ************************************
  // Pin and monitors
  // ************************************
  // Sole driver of the pin; short holds model glitches
  assign o_clear_pin_n     = i_pin_hold ? 1'b0 : 1'b1;
  assign o_brownout        = i_brownout_req;
  assign o_watchdog_expire = i_watchdog_req;
endmodule

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the reset source and init control block.
// Assumes: FILT_CYC set to 4 to keep pin tests short.
// Notes:   Random values come from a fixed seed.
`timescale 1ns/1ps
module testbench;
  localparam int FILT = 4;
  logic        i_mclk, i_rst_n, i_clear_pin_n, i_brownout, i_watchdog_expire, pin_hold;
  logic        brownout_req, watchdog_req;
  logic        i_reset_instr, i_stack_full, i_stack_underflow, i_sleeping, i_wake_irq;
  logic        i_irq_high, i_high_priority_global_enable, i_low_priority_global_enable;
  logic        i_irq_ctrl_keep, i_wr, i_rd, o_core_rst_n, o_gpr_cold, o_long_write_clr;
  logic        o_pc_load, o_tos_load, o_irq, irq, gie;
  logic [20:0] i_pc, o_pc_value, o_tos_value;
  logic [4:0]  i_stack_pointer, o_stack_pointer_value;
  logic [7:0]  i_port_a_pins, i_port_a_latch, i_port_a_direction, i_wdata, o_rdata;
  logic [7:0]  o_port_a_pins, o_port_a_latch, o_port_a_direction, o_irq_ctrl_value, pa;
  logic [2:0]  i_addr;
  logic [1:0]  o_wake_flag_set;
  int          bad_count, tests_run, cyc;
  // Brown-out first, watchdog last to change the flags
  int          k_list [4] = '{4, 3, 6, 7};

  rsic_far_side u_far (.i_pin_hold(pin_hold), .i_brownout_req(brownout_req),
    .i_watchdog_req(watchdog_req), .o_clear_pin_n(i_clear_pin_n), .o_brownout(i_brownout),
    .o_watchdog_expire(i_watchdog_expire));

  rsic_top #(.FILT_CYC(FILT)) u_dut (.i_mclk, .i_rst_n, .i_clear_pin_n, .i_brownout,
    .i_watchdog_expire, .i_reset_instr, .i_stack_full, .i_stack_underflow, .i_sleeping,
    .i_wake_irq, .i_irq_high,
    .i_high_priority_global_enable, .i_low_priority_global_enable, .i_pc, .i_stack_pointer,
    .i_irq_ctrl_keep, .i_port_a_pins, .i_port_a_latch, .i_port_a_direction, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .o_core_rst_n, .o_gpr_cold, .o_long_write_clr, .o_irq_ctrl_value,
    .o_pc_load, .o_pc_value, .o_tos_load, .o_tos_value, .o_stack_pointer_value,
    .o_wake_flag_set, .o_port_a_pins, .o_port_a_latch, .o_port_a_direction, .o_irq);

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  // ************************************
  // Helpers
  // ************************************
  function automatic logic [7:0] exp_pa(input logic [7:0] v, input logic [2:0] m);
    exp_pa = v;
    if (m !== rsic_pkg::OSC_EXT_IO && m !== rsic_pkg::OSC_RCAP_IO) begin
      exp_pa[6] = 1'b0;
    end
  endfunction

  function automatic logic [20:0] exp_pc(input logic w, input logic g, input logic h,
                                         input logic [20:0] pc);
    if (w && g) begin
      exp_pc = h ? rsic_pkg::VEC_HIGH : rsic_pkg::VEC_LOW;
    end else begin
      exp_pc = pc + rsic_pkg::PC_STEP;
    end
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic chk_rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp, "register read");
  endtask

  // One-cycle event: 3 watchdog, 4 brown-out, 5 instruction, 6 stack full, 7 underflow
  task automatic fire(input int idx);
    @(posedge i_mclk);
    watchdog_req <= (idx == 3);
    brownout_req <= (idx == 4);
    i_reset_instr <= (idx == 5);
    i_stack_full <= (idx == 6);
    i_stack_underflow <= (idx == 7);
    @(posedge i_mclk);
    {watchdog_req, brownout_req, i_reset_instr, i_stack_full, i_stack_underflow} <= '0;
    #1 chk(o_core_rst_n, 0, "reset entry");
  endtask

  task automatic wait_run();
    int n;
    n = 0;
    while (o_core_rst_n !== 1'b1 && n < 40) begin
      @(posedge i_mclk);
      #1 n++;
    end
    chk(o_core_rst_n, 1, "reset release");
  endtask

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      test_done();
    end
  end

  // ************************************
  // Sequence
  // ************************************
  initial begin
    {i_rst_n, pin_hold, brownout_req, watchdog_req, i_reset_instr} = '0;
    {i_stack_full, i_stack_underflow} = '0;
    {i_sleeping, i_wake_irq, i_irq_high, i_high_priority_global_enable} = '0;
    {i_low_priority_global_enable, i_irq_ctrl_keep, i_wr, i_rd} = '0;
    {i_pc, i_stack_pointer, i_port_a_pins, i_port_a_latch, i_port_a_direction} = '0;
    {i_addr, i_wdata} = '0;
    void'($urandom(52562));
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    #1 chk(o_gpr_cold, 1, "cold flag");
    chk(o_long_write_clr, 1, "long write clear on power-on");
    wait_run();
    // Both flags drop one edge after the core leaves reset
    @(posedge i_mclk);
    #1 chk(o_gpr_cold, 0, "cold flag after release");
    chk(o_long_write_clr, 0, "long write kept");
    chk_rd(rsic_pkg::ADDR_CAUSE, {3'h0, rsic_pkg::CAUSE_COLD});
    chk_rd(rsic_pkg::ADDR_LAST, 8'h01);
    chk_rd(rsic_pkg::ADDR_MASK, 8'h00);
    chk_rd(rsic_pkg::ADDR_CTRL, 8'h00);
    wr(rsic_pkg::ADDR_CAUSE, 8'h00);
    chk_rd(rsic_pkg::ADDR_CAUSE, 8'h0c);
    chk_rd(3'h6, 8'h00);
    @(posedge i_mclk);
    i_irq_ctrl_keep <= 1'($urandom);
    fire(5);
    chk(o_irq_ctrl_value, {13'h0, 7'h00, i_irq_ctrl_keep}, "interrupt control init");
    @(posedge i_mclk);
    #1 chk(o_core_rst_n, 0, "hold");
    @(posedge i_mclk);
    #1 chk(o_core_rst_n, 1, "synchronous release");
    chk_rd(rsic_pkg::ADDR_LAST, 8'h20);
    chk_rd(rsic_pkg::ADDR_CAUSE, 8'h0c);
    foreach (k_list[i]) begin
      fire(k_list[i]);
      chk(o_long_write_clr, 0, "long write kept on warm reset");
      wait_run();
      chk_rd(rsic_pkg::ADDR_LAST, 8'h01 << k_list[i]);
    end
    chk_rd(rsic_pkg::ADDR_CAUSE, 8'h14);
    chk_rd(rsic_pkg::ADDR_STATUS, 8'hf9);
    wr(rsic_pkg::ADDR_MASK, 8'h20);
    chk(o_irq, 1, "unmasked status raises irq");
    wr(rsic_pkg::ADDR_STATUS, 8'hff);
    chk(o_irq, 0, "cleared status drops irq");
    chk_rd(rsic_pkg::ADDR_STATUS, 8'h00);
    wr(rsic_pkg::ADDR_MASK, 8'h40);
    fire(6);
    wait_run();
    chk(o_irq, 1, "new event raises irq");
    wr(rsic_pkg::ADDR_MASK, 8'h00);
    chk(o_irq, 0, "masked event");
    @(posedge i_mclk);
    pin_hold <= 1'b1;
    repeat (FILT - 1) @(posedge i_mclk);
    pin_hold <= 1'b0;
    repeat (4) begin
      @(posedge i_mclk);
      #1 chk(o_core_rst_n, 1, "short pin low ignored");
    end
    @(posedge i_mclk);
    pin_hold <= 1'b1;
    repeat (FILT + 2) @(posedge i_mclk);
    #1 chk(o_core_rst_n, 0, "sustained pin low resets");
    chk(o_long_write_clr, 1, "pin clear clears long write");
    @(posedge i_mclk);
    pin_hold <= 1'b0;
    wait_run();
    chk_rd(rsic_pkg::ADDR_LAST, 8'h02);
    @(posedge i_mclk);
    i_sleeping <= 1'b1;
    repeat (16) begin
      @(posedge i_mclk);
      irq = 1'($urandom);
      i_high_priority_global_enable <= 1'($urandom);
      i_low_priority_global_enable <= 1'($urandom);
      i_irq_high <= 1'($urandom);
      i_pc <= 21'($urandom);
      i_stack_pointer <= 5'($urandom);
      i_wake_irq <= irq;
      watchdog_req <= ~irq;
      @(posedge i_mclk);
      i_wake_irq <= 1'b0;
      watchdog_req <= 1'b0;
      gie = i_high_priority_global_enable | i_low_priority_global_enable;
      #1 chk(o_core_rst_n, 1, "wake keeps running");
      chk(o_pc_load, 1, "pc load on wake");
      chk(o_pc_value, exp_pc(irq, gie, i_irq_high, i_pc), "wake pc");
      chk(o_wake_flag_set, {~irq, irq}, "wake flag");
      chk(o_tos_load, irq & gie, "stack push");
      if (irq && gie) begin
        chk(o_tos_value, i_pc, "top of stack");
        chk(o_stack_pointer_value, 5'(i_stack_pointer + rsic_pkg::SP_STEP), "sp");
      end
    end
    chk_rd(rsic_pkg::ADDR_CAUSE, irq ? 8'h18 : 8'h10);
    // Pin clear while asleep
    @(posedge i_mclk);
    pin_hold <= 1'b1;
    repeat (FILT + 2) @(posedge i_mclk);
    #1 chk(o_long_write_clr, 1, "sleep pin clear clears long write");
    @(posedge i_mclk);
    pin_hold <= 1'b0;
    wait_run();
    chk_rd(rsic_pkg::ADDR_LAST, 8'h04);
    chk_rd(rsic_pkg::ADDR_CAUSE, 8'h18);
    @(posedge i_mclk);
    i_sleeping <= 1'b0;
    for (int m = 0; m < 8; m++) begin
      wr(rsic_pkg::ADDR_CTRL, 8'(m));
      pa = 8'($urandom) | 8'h40;
      @(posedge i_mclk);
      i_port_a_pins <= pa;
      i_port_a_latch <= ~pa | 8'h40;
      i_port_a_direction <= pa;
      @(posedge i_mclk);
      #1 chk(o_port_a_pins, exp_pa(pa, 3'(m)), "port pins");
      chk(o_port_a_latch, exp_pa(~pa | 8'h40, 3'(m)), "port latch");
      chk(o_port_a_direction, exp_pa(pa, 3'(m)), "port direction");
    end
    test_done();
  end

endmodule
